//--- rtl/bbx_exec.sv
// Purpose: execute stage for relative flag branches, io bit ops, shifts and flag ops
// Assumes: one decoded instruction per cycle on instr_i while ready_o is high
// Notes:   io registers, status and pc are also reachable over the register port
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "bbx_defs.svh"

// Functional notes
// [RQ1] overflow set: branch to pc plus offset plus one, one or two cycles
// [RQ2] overflow clear: branch to pc plus offset plus one, else next instruction
// [RQ3] interrupts enabled: relative jump of offset plus one, else advance
// [RQ4] interrupts disabled: relative jump of offset plus one, else advance
// [RQ5] io bit set forces chosen io bit high, others kept
// [RQ6] io bit clear forces chosen io bit low, others kept
// [RQ7] logical left shift moves bits up, zero into bit zero
// [RQ8] logical right shift moves bits down, zero into bit seven
// [RQ9] rotate left: old carry into bit zero, bit seven becomes carry
// [RQ10] rotate right: old carry into bit seven, bit zero becomes carry
// [RQ11] generic flag set or clear touches only the selected status flag
// [RQ12] bit store copies chosen register bit into the transfer flag
// [RQ13] bit load copies transfer flag into chosen bit, others kept
// [RQ14] carry set and clear drive carry one or zero only
// [RQ15] negative set and zero set drive their flag to one
module bbx_exec (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  // instruction in
  input  wire bbx_pkg::bbx_instr_s       instr_i,
  output logic                           ready_o,
  // register file write back
  output bbx_pkg::bbx_wb_s               wb_o,
  // core state
  output logic [`BBX_PC_W-1:0]           pc_o,
  output logic [`BBX_DATA_W-1:0]         status_o,
  // register port
  input  wire bbx_pkg::bbx_bus_s         bus_i,
  output logic [`BBX_DATA_W-1:0]         bus_rdata_o
);
  import bbx_pkg::*;

  bbx_state_s state_q;
  bbx_state_s state_d;

  // one-hot mask of a bit index
  function automatic logic [`BBX_DATA_W-1:0] bit_mask(input logic [2:0] idx);
    logic [`BBX_DATA_W-1:0] m;
    m = 8'h00;
    m[idx] = 1'b1;
    return m;
  endfunction

  // sign extend the branch offset to pc width
  function automatic logic [`BBX_PC_W-1:0] sext_k(input logic [`BBX_K_W-1:0] k);
    return {{(`BBX_PC_W-`BBX_K_W){k[`BBX_K_W-1]}}, k};
  endfunction

  // flags after a shift or rotate
  function automatic logic [`BBX_DATA_W-1:0] shift_flags(
    input logic [`BBX_DATA_W-1:0] sr,
    input logic [`BBX_DATA_W-1:0] res,
    input logic                   cout,
    input logic                   half,
    input logic                   upd_half
  );
    logic [`BBX_DATA_W-1:0] f;
    logic                   n;
    logic                   v;
    f = sr;
    n = res[`BBX_DATA_W-1];
    v = n ^ cout;
    f[`BBX_FLAG_C] = cout;
    f[`BBX_FLAG_Z] = (res == 8'h00);
    f[`BBX_FLAG_N] = n;
    f[`BBX_FLAG_V] = v;
    f[`BBX_FLAG_S] = n ^ v;
    if (upd_half) begin
      f[`BBX_FLAG_H] = half;
    end
    return f;
  endfunction

  // decoded register port reads
  logic [`BBX_DATA_W-1:0] io_rd_val;
  logic [`BBX_DATA_W-1:0] bus_rd_val;
  logic                   take_branch;
  logic [`BBX_PC_W-1:0]   pc_seq;
  logic [`BBX_PC_W-1:0]   pc_jump;
  logic [`BBX_DATA_W-1:0] shift_res;
  logic [`BBX_DATA_W-1:0] bmask;
  logic                   accept;

  assign io_rd_val = state_q.io[bus_i.addr[`BBX_IO_AW-1:0]];

  always_comb begin
    if (bus_i.addr <= `BBX_ADDR_IO_LAST) begin
      bus_rd_val = io_rd_val;
    end else if (bus_i.addr == `BBX_ADDR_STATUS) begin
      bus_rd_val = state_q.status;
    end else if (bus_i.addr == `BBX_ADDR_PC_LO) begin
      bus_rd_val = state_q.pc[7:0];
    end else if (bus_i.addr == `BBX_ADDR_PC_HI) begin
      bus_rd_val = {5'h00, state_q.pc[`BBX_PC_W-1:8]};
    end else begin
      bus_rd_val = 8'h00;
    end
  end

  // branch decision and targets
  assign accept  = instr_i.valid & ~state_q.stall;
  assign pc_seq  = state_q.pc + 11'h001;
  assign pc_jump = state_q.pc + sext_k(instr_i.k) + 11'h001;
  assign bmask   = bit_mask(instr_i.bsel);

  always_comb begin
    case (instr_i.op)
      OP_BRANCH_OVERFLOW_SET: begin
        take_branch = state_q.status[`BBX_FLAG_V];                 // [RQ1]
      end
      OP_BRANCH_OVERFLOW_CLR: begin
        take_branch = ~state_q.status[`BBX_FLAG_V];                // [RQ2]
      end
      OP_BRANCH_IRQ_ENABLED: begin
        take_branch = state_q.status[`BBX_FLAG_I];                 // [RQ3]
      end
      OP_BRANCH_IRQ_DISABLED: begin
        take_branch = ~state_q.status[`BBX_FLAG_I];                // [RQ4]
      end
      default: begin
        take_branch = 1'b0;
      end
    endcase
  end

  // shift and rotate results
  always_comb begin
    case (instr_i.op)
      OP_SHIFT_LEFT_LOGICAL: begin
        shift_res = {instr_i.rd_val[6:0], 1'b0};                   // [RQ7]
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        shift_res = {1'b0, instr_i.rd_val[7:1]};                   // [RQ8]
      end
      OP_ROTATE_LEFT_CARRY: begin
        shift_res = {instr_i.rd_val[6:0], state_q.status[`BBX_FLAG_C]}; // [RQ9]
      end
      OP_ROTATE_RIGHT_CARRY: begin
        shift_res = {state_q.status[`BBX_FLAG_C], instr_i.rd_val[7:1]}; // [RQ10]
      end
      default: begin
        shift_res = instr_i.rd_val;
      end
    endcase
  end

  // next state
  always_comb begin
    state_d       = state_q;
    state_d.wb.we = 1'b0;
    state_d.stall = 1'b0;

    // register port read data, valid the cycle after the strobe
    if (bus_i.rd) begin
      state_d.rdata = bus_rd_val;
    end

    // register port writes
    if (bus_i.wr) begin
      if (bus_i.addr <= `BBX_ADDR_IO_LAST) begin
        state_d.io[bus_i.addr[`BBX_IO_AW-1:0]] = bus_i.wdata;
      end else if (bus_i.addr == `BBX_ADDR_STATUS) begin
        state_d.status = bus_i.wdata;
      end else if (bus_i.addr == `BBX_ADDR_PC_LO) begin
        state_d.pc[7:0] = bus_i.wdata;
      end else if (bus_i.addr == `BBX_ADDR_PC_HI) begin
        state_d.pc[`BBX_PC_W-1:8] = bus_i.wdata[`BBX_PC_W-9:0];
      end
    end

    // instruction execution, wins over a same-cycle port write
    if (accept) begin
      state_d.pc = pc_seq;
      case (instr_i.op)
        OP_BRANCH_OVERFLOW_SET,
        OP_BRANCH_OVERFLOW_CLR,
        OP_BRANCH_IRQ_ENABLED,
        OP_BRANCH_IRQ_DISABLED: begin
          if (take_branch) begin
            state_d.pc    = pc_jump;                               // [RQ1] [RQ2] [RQ3] [RQ4]
            state_d.stall = 1'b1;                                  // [RQ1]
          end
        end
        OP_IO_BIT_SET: begin
          state_d.io[instr_i.io_addr] = state_q.io[instr_i.io_addr] | bmask;  // [RQ5]
        end
        OP_IO_BIT_CLEAR: begin
          state_d.io[instr_i.io_addr] = state_q.io[instr_i.io_addr] & ~bmask; // [RQ6]
        end
        OP_SHIFT_LEFT_LOGICAL: begin
          state_d.wb.we   = 1'b1;                                  // [RQ7]
          state_d.wb.data = shift_res;
          state_d.status  = shift_flags(state_q.status, shift_res,
                                        instr_i.rd_val[7], instr_i.rd_val[3], 1'b1);
        end
        OP_SHIFT_RIGHT_LOGICAL: begin
          state_d.wb.we   = 1'b1;                                  // [RQ8]
          state_d.wb.data = shift_res;
          state_d.status  = shift_flags(state_q.status, shift_res,
                                        instr_i.rd_val[0], 1'b0, 1'b0);
        end
        OP_ROTATE_LEFT_CARRY: begin
          state_d.wb.we   = 1'b1;                                  // [RQ9]
          state_d.wb.data = shift_res;
          state_d.status  = shift_flags(state_q.status, shift_res,
                                        instr_i.rd_val[7], instr_i.rd_val[3], 1'b1);
        end
        OP_ROTATE_RIGHT_CARRY: begin
          state_d.wb.we   = 1'b1;                                  // [RQ10]
          state_d.wb.data = shift_res;
          state_d.status  = shift_flags(state_q.status, shift_res,
                                        instr_i.rd_val[0], 1'b0, 1'b0);
        end
        OP_FLAG_SET_GENERIC: begin
          state_d.status = state_q.status | bmask;                 // [RQ11]
        end
        OP_FLAG_CLEAR_GENERIC: begin
          state_d.status = state_q.status & ~bmask;                // [RQ11]
        end
        OP_BIT_TO_TRANSFER_FLAG: begin
          state_d.status              = state_q.status;
          state_d.status[`BBX_FLAG_T] = instr_i.rd_val[instr_i.bsel]; // [RQ12]
        end
        OP_TRANSFER_FLAG_TO_BIT: begin
          state_d.wb.we   = 1'b1;                                  // [RQ13]
          state_d.wb.data = state_q.status[`BBX_FLAG_T] ? (instr_i.rd_val | bmask)
                                                        : (instr_i.rd_val & ~bmask);
        end
        OP_CARRY_SET: begin
          state_d.status = state_q.status | bit_mask(`BBX_FLAG_C);  // [RQ14]
        end
        OP_CARRY_CLEAR: begin
          state_d.status = state_q.status & ~bit_mask(`BBX_FLAG_C); // [RQ14]
        end
        OP_NEGATIVE_SET: begin
          state_d.status = state_q.status | bit_mask(`BBX_FLAG_N);  // [RQ15]
        end
        OP_ZERO_SET: begin
          state_d.status = state_q.status | bit_mask(`BBX_FLAG_Z);  // [RQ15]
        end
        default: begin
          state_d.pc = pc_seq;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q.pc      <= `BBX_RST_PC;
      state_q.status  <= `BBX_RST_STATUS;
      state_q.io      <= '0;
      state_q.stall   <= 1'b0;
      state_q.wb      <= '0;
      state_q.rdata   <= 8'h00;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs
  assign ready_o     = ~state_q.stall;                             // [RQ1]
  assign wb_o        = state_q.wb;
  assign pc_o        = state_q.pc;
  assign status_o    = state_q.status;
  assign bus_rdata_o = state_q.rdata;

endmodule // bbx_exec

//--- include/bbx_defs.svh
// Purpose: constants for the branch, bit and shift execute block
// Assumes: 8-bit data path, word-addressed program counter
// Notes:   offsets are byte addresses of the plain register port
`ifndef BBX_DEFS_SVH
`define BBX_DEFS_SVH

// widths
`define BBX_PC_W        11
`define BBX_DATA_W      8
`define BBX_IO_AW       5
`define BBX_IO_N        32
`define BBX_K_W         7
`define BBX_BUS_AW      8

// status flag positions
`define BBX_FLAG_C      3'h0
`define BBX_FLAG_Z      3'h1
`define BBX_FLAG_N      3'h2
`define BBX_FLAG_V      3'h3
`define BBX_FLAG_S      3'h4
`define BBX_FLAG_H      3'h5
`define BBX_FLAG_T      3'h6
`define BBX_FLAG_I      3'h7

// register port map
`define BBX_ADDR_IO_LAST 8'h1F
`define BBX_ADDR_STATUS  8'h20
`define BBX_ADDR_PC_LO   8'h21
`define BBX_ADDR_PC_HI   8'h22

// reset values
`define BBX_RST_STATUS  8'h00
`define BBX_RST_PC      11'h000
`define BBX_RST_IO      8'h00

// branch timing in cycles
`define BBX_BR_CYC_TAKEN 2'h2
`define BBX_BR_CYC_NOT   2'h1

`endif

//--- include/bbx_pkg.sv
// Purpose: types for the branch, bit and shift execute block
// Assumes: constants come from bbx_defs.svh
// Notes:   op codes are internal decode results
`include "bbx_defs.svh"

package bbx_pkg;

  typedef enum logic [4:0] {
    OP_NOP                  = 5'h00,
    OP_BRANCH_OVERFLOW_SET  = 5'h01,
    OP_BRANCH_OVERFLOW_CLR  = 5'h02,
    OP_BRANCH_IRQ_ENABLED   = 5'h03,
    OP_BRANCH_IRQ_DISABLED  = 5'h04,
    OP_IO_BIT_SET           = 5'h05,
    OP_IO_BIT_CLEAR         = 5'h06,
    OP_SHIFT_LEFT_LOGICAL   = 5'h07,
    OP_SHIFT_RIGHT_LOGICAL  = 5'h08,
    OP_ROTATE_LEFT_CARRY    = 5'h09,
    OP_ROTATE_RIGHT_CARRY   = 5'h0A,
    OP_FLAG_SET_GENERIC     = 5'h0B,
    OP_FLAG_CLEAR_GENERIC   = 5'h0C,
    OP_BIT_TO_TRANSFER_FLAG = 5'h0D,
    OP_TRANSFER_FLAG_TO_BIT = 5'h0E,
    OP_CARRY_SET            = 5'h0F,
    OP_CARRY_CLEAR          = 5'h10,
    OP_NEGATIVE_SET         = 5'h11,
    OP_ZERO_SET             = 5'h12
  } bbx_op_e;

  typedef struct packed {
    logic                       valid;
    bbx_op_e                    op;
    logic [`BBX_K_W-1:0]        k;
    logic [2:0]                 bsel;
    logic [`BBX_IO_AW-1:0]      io_addr;
    logic [`BBX_DATA_W-1:0]     rd_val;
  } bbx_instr_s;

  typedef struct packed {
    logic                       we;
    logic [`BBX_DATA_W-1:0]     data;
  } bbx_wb_s;

  typedef struct packed {
    logic                       wr;
    logic                       rd;
    logic [`BBX_BUS_AW-1:0]     addr;
    logic [`BBX_DATA_W-1:0]     wdata;
  } bbx_bus_s;

  typedef struct packed {
    logic [`BBX_PC_W-1:0]                   pc;
    logic [`BBX_DATA_W-1:0]                 status;
    logic [`BBX_IO_N-1:0][`BBX_DATA_W-1:0]  io;
    logic                                   stall;
    bbx_wb_s                                wb;
    logic [`BBX_DATA_W-1:0]                 rdata;
  } bbx_state_s;

endpackage

//--- dv/bbx_exec_properties.sv
// Purpose: port assertions for bbx_exec
// Assumes: no bus write to status or pc beside an instruction
// Notes:   bound to every bbx_exec
`timescale 1ns/1ps
`include "bbx_defs.svh"
module bbx_exec_chk
  import bbx_pkg::*;
(
  // clock and reset
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  // watched ports
  input wire bbx_pkg::bbx_instr_s     instr_i,
  input wire logic                    ready_o,
  input wire bbx_pkg::bbx_wb_s        wb_o,
  input wire logic [`BBX_PC_W-1:0]    pc_o,
  input wire logic [`BBX_DATA_W-1:0]  status_o,
  input wire bbx_pkg::bbx_bus_s       bus_i,
  input wire logic [`BBX_DATA_W-1:0]  bus_rdata_o
);
  logic                   take;
  logic                   sel_bit;
  logic [7:0]             rd;
  logic [`BBX_PC_W-1:0]   tgt;
  assign take    = instr_i.valid && ready_o;
  assign rd      = instr_i.rd_val;
  assign sel_bit = rd[instr_i.bsel];
  assign tgt     = pc_o + {{4{instr_i.k[6]}}, instr_i.k} + 11'h001;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // jump target lands in the one stall cycle, then ready returns
  sequence jump_s;
    pc_o == $past(tgt) && !ready_o ##1 ready_o;
  endsequence
  ovs_jump_a: assert property (take && instr_i.op == OP_BRANCH_OVERFLOW_SET && status_o[3] |=> jump_s)
    else $error("overflow set branch wrong");
  ovc_jump_a: assert property (take && instr_i.op == OP_BRANCH_OVERFLOW_CLR && !status_o[3] |=> jump_s)
    else $error("overflow clear branch wrong");
  irq_en_jump_a: assert property (take && instr_i.op == OP_BRANCH_IRQ_ENABLED && status_o[7] |=> jump_s)
    else $error("irq enabled branch wrong");
  irq_dis_jump_a: assert property (take && instr_i.op == OP_BRANCH_IRQ_DISABLED && !status_o[7] |=> jump_s)
    else $error("irq disabled branch wrong");
  shl_result_a: assert property (take && instr_i.op == OP_SHIFT_LEFT_LOGICAL |=> wb_o.we
    && wb_o.data == {$past(rd[6:0]), 1'b0} && status_o[0] == $past(rd[7])) else $error("left shift wrong");
  shr_result_a: assert property (take && instr_i.op == OP_SHIFT_RIGHT_LOGICAL |=> wb_o.we
    && wb_o.data == {1'b0, $past(rd[7:1])} && status_o[0] == $past(rd[0])) else $error("right shift wrong");
  rotl_result_a: assert property (take && instr_i.op == OP_ROTATE_LEFT_CARRY |=> wb_o.we
    && wb_o.data == {$past(rd[6:0]), $past(status_o[0])} && status_o[0] == $past(rd[7]))
    else $error("rotate left wrong");
  rotr_result_a: assert property (take && instr_i.op == OP_ROTATE_RIGHT_CARRY |=> wb_o.we
    && wb_o.data == {$past(status_o[0]), $past(rd[7:1])} && status_o[0] == $past(rd[0]))
    else $error("rotate right wrong");
  flag_set_a: assert property (take && instr_i.op == OP_FLAG_SET_GENERIC
    |=> status_o == ($past(status_o) | (8'h01 << $past(instr_i.bsel)))) else $error("flag set wrong");
  bit_store_a: assert property (take && instr_i.op == OP_BIT_TO_TRANSFER_FLAG |=> status_o[6] == $past(sel_bit))
    else $error("bit store wrong");
  carry_clear_a: assert property (take && instr_i.op == OP_CARRY_CLEAR
    |=> status_o == ($past(status_o) & 8'hFE)) else $error("carry clear wrong");
  neg_set_a: assert property (take && instr_i.op == OP_NEGATIVE_SET |=> status_o[2])
    else $error("negative set wrong");
endmodule // bbx_exec_chk

bind bbx_exec bbx_exec_chk i_bbx_exec_chk (.sys_clk_i, .rst_n_i, .instr_i, .ready_o, .wb_o, .pc_o,
  .status_o, .bus_i, .bus_rdata_o);

//--- dv/bbx_exec_bench.sv
// Purpose: self-checking bench for bbx_exec
// Assumes: bus and instruction traffic never share a cycle
// Notes:   pc tracked by the bench itself
`timescale 1ns/1ps
`include "bbx_defs.svh"
module bbx_exec_bench;
  import bbx_pkg::*;
  logic                     sys_clk_i;
  logic                     rst_n_i;
  logic                     ready_o;
  bbx_instr_s               instr_i;
  bbx_wb_s                  wb_o;
  bbx_bus_s                 bus_i;
  logic [`BBX_PC_W-1:0]     pc_o;
  logic [`BBX_PC_W-1:0]     pc_m;
  logic [`BBX_DATA_W-1:0]   status_o;
  logic [`BBX_DATA_W-1:0]   bus_rdata_o;
  int                       err_count;
  int                       samples_checked;
  bbx_exec i_bbx_exec (.sys_clk_i, .rst_n_i, .instr_i, .ready_o, .wb_o, .pc_o, .status_o, .bus_i, .bus_rdata_o);
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic issue(input bbx_op_e op, input logic [6:0] k, input logic [2:0] b, input logic [4:0] a,
                       input logic [7:0] rd);
    @(posedge sys_clk_i);
    instr_i <= '{1'b1, op, k, b, a, rd};
    @(posedge sys_clk_i);
    instr_i.valid <= 1'b0;
    #1;
    pc_m = pc_m + 11'h001;
  endtask
  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_i <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    bus_i <= '0;
  endtask
  task automatic brd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    bus_i <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i);
    bus_i <= '0;
    #1;
    check(bus_rdata_o, exp);
  endtask
  // each branch op once taken and once not, negative offset for the overflow ops, positive for the irq ops
  task automatic t_branch();
    logic [6:0] k;
    logic       tk;
    bwr(8'h21, 8'hF0);
    bwr(8'h22, 8'h03);
    pc_m = 11'h3F0;
    for (int i = 0; i < 8; i++) begin
      k  = (i < 4) ? 7'h40 : 7'h3F;
      tk = i[0] ^ i[1];
      bwr(8'h20, i[0] ? 8'h88 : 8'h00);
      issue(bbx_op_e'(5'h01 + 5'(i >> 1)), k, 3'h0, 5'h00, 8'h00);
      if (tk) begin
        pc_m = pc_m + {{4{k[6]}}, k};
      end
      check(pc_o, pc_m);
      check(ready_o, !tk);
    end
  endtask
  task automatic t_io();
    bwr(8'h05, 8'hA5);
    issue(OP_IO_BIT_SET, 7'h00, 3'h1, 5'h05, 8'h00);
    issue(OP_IO_BIT_CLEAR, 7'h00, 3'h7, 5'h05, 8'h00);
    brd(8'h05, 8'h27);
    issue(OP_IO_BIT_SET, 7'h00, 3'h0, 5'h1F, 8'h00);
    brd(8'h1F, 8'h01);
    brd(8'h04, 8'h00);
    bwr(8'h23, 8'h55);
    brd(8'h23, 8'h00);
    check(pc_o, pc_m);
  endtask
  task automatic t_shift();
    bwr(8'h20, 8'h00);
    issue(OP_SHIFT_LEFT_LOGICAL, 7'h00, 3'h0, 5'h00, 8'h81);
    check({wb_o.we, wb_o.data, status_o[0]}, {1'b1, 8'h02, 1'b1});
    issue(OP_ROTATE_LEFT_CARRY, 7'h00, 3'h0, 5'h00, 8'h40);
    check({wb_o.we, wb_o.data, status_o[0]}, {1'b1, 8'h81, 1'b0});
    issue(OP_SHIFT_RIGHT_LOGICAL, 7'h00, 3'h0, 5'h00, 8'h81);
    check({wb_o.we, wb_o.data, status_o[0]}, {1'b1, 8'h40, 1'b1});
    issue(OP_ROTATE_RIGHT_CARRY, 7'h00, 3'h0, 5'h00, 8'h02);
    check({wb_o.we, wb_o.data, status_o[0]}, {1'b1, 8'h81, 1'b0});
  endtask
  task automatic t_flags();
    bbx_op_e    ops[8] = '{OP_FLAG_SET_GENERIC, OP_CARRY_SET, OP_NEGATIVE_SET, OP_ZERO_SET, OP_CARRY_CLEAR,
                           OP_FLAG_CLEAR_GENERIC, OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT};
    logic [2:0] bs[8]  = '{3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 3'h5, 3'h4, 3'h2};
    logic [7:0] rv[8]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h81};
    logic [7:0] ex[8]  = '{8'h20, 8'h21, 8'h25, 8'h27, 8'h26, 8'h06, 8'h46, 8'h46};
    bwr(8'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      issue(ops[i], 7'h00, bs[i], 5'h00, rv[i]);
      check(status_o, ex[i]);
    end
    check({wb_o.we, wb_o.data}, {1'b1, 8'h85});
    // clear transfer flag, then load a zero into a set bit
    issue(OP_BIT_TO_TRANSFER_FLAG, 7'h00, 3'h3, 5'h00, 8'hF7);
    check(status_o, 8'h06);
    issue(OP_TRANSFER_FLAG_TO_BIT, 7'h00, 3'h2, 5'h00, 8'hFF);
    check({wb_o.we, wb_o.data}, {1'b1, 8'hFB});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    rst_n_i = 1'b0;
    instr_i = '0;
    bus_i = '0;
    pc_m = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_branch();
    t_io();
    t_shift();
    t_flags();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_count++;
    tally_and_finish();
  end
endmodule // bbx_exec_bench
